/* File: hw/pfs_top.sv */
`timescale 1ns/1ps

module pfs_top (
    input  wire logic                          pclk,
    input  wire logic                          presetn,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [pfs_pkg::PFS_ADDR_W-1:0] paddr,
    input  wire logic [31:0]                   pwdata,
    output logic      [31:0]                   prdata,
    output logic                               pready,
    output logic                               pslverr,
    input  wire logic                          crystal_input_clock,
    input  wire logic                          transmit_line_clock,
    input  wire logic                          indicator_a_src,
    input  wire logic                          indicator_b_src,
    input  wire logic                          indicator_c_src,
    input  wire logic                          wake_on_lan_indication,
    input  wire logic                          undervoltage_indication,
    input  wire logic                          ts_transmit_event,
    input  wire logic                          ts_receive_event,
    output logic                               indicator_pin_a,
    output logic                               indicator_pin_b,
    output logic                               clock_output_pin,
    output logic      [pfs_pkg::PFS_TERM_W-1:0] rx_term_code
);
    import pfs_pkg::*;

    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------
    logic [15:0] term_q, term_d;
    logic [15:0] ctl1_q, ctl1_d;
    logic [15:0] ctl2_q, ctl2_d;
    logic [31:0] prdata_q, prdata_d;
    logic        pready_q, pready_d;
    logic        pslverr_q, pslverr_d;
    logic [15:0] rd_word;
    logic        hit;
    logic        wr_en;

    always_comb begin
        hit     = 1'b1;
        rd_word = 16'h0000;
        unique case (paddr)
            PFS_ADDR_TERM: rd_word = term_q;
            PFS_ADDR_CTL1: rd_word = ctl1_q;
            PFS_ADDR_CTL2: rd_word = ctl2_q;
            default:       hit     = 1'b0;
        endcase
    end

    // Writes land at the access edge where pready is sampled high.
    assign wr_en = psel & penable & pready_q & pwrite & hit;

    always_comb begin
        term_d    = term_q;
        ctl1_d    = ctl1_q;
        ctl2_d    = ctl2_q;
        prdata_d  = prdata_q;
        pslverr_d = 1'b0;
        // A one-cycle answer: pready rises in the first access cycle.
        pready_d  = psel & ~penable;
        if (psel & ~penable) begin
            prdata_d  = {16'h0000, rd_word};
            pslverr_d = ~hit;
        end
        if (wr_en && paddr == PFS_ADDR_TERM) begin
            term_d = pwdata[15:0] & PFS_TERM_MASK;
        end
        if (wr_en && paddr == PFS_ADDR_CTL1) begin
            ctl1_d = pwdata[15:0] & PFS_CTL1_MASK;
        end
        if (wr_en && paddr == PFS_ADDR_CTL2) begin
            ctl2_d = pwdata[15:0] & PFS_CTL2_MASK;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            term_q    <= PFS_TERM_RST;
            ctl1_q    <= PFS_CTL1_RST;
            ctl2_q    <= PFS_CTL2_RST;
            prdata_q  <= 32'h0000_0000;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            term_q    <= term_d;
            ctl1_q    <= ctl1_d;
            ctl2_q    <= ctl2_d;
            prdata_q  <= prdata_d;
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;

    // ----------------------------------------------------------------
    // Receive output termination
    // ----------------------------------------------------------------
    // One code fans out to every receive output driver; there is no
    // per-line copy, so the lines can never disagree.
    logic [PFS_TERM_W-1:0] term_out_q, term_out_d;

    assign term_out_d = term_q[PFS_TERM_LSB +: PFS_TERM_W];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            term_out_q <= PFS_TERM_RST[PFS_TERM_LSB +: PFS_TERM_W];
        end else begin
            term_out_q <= term_out_d;
        end
    end

    assign rx_term_code = term_out_q;

    // ----------------------------------------------------------------
    // Pin function multiplexers
    // ----------------------------------------------------------------
    // Index 0 is indicator pin a, 1 is pin b, 2 is the clock output pin.
    // Clock sources are sampled as ordinary inputs, so a routed clock
    // appears one cycle late and is only faithful below half of pclk.
    logic [2:0] func_sel [3];
    logic [3:0] clk_sel  [3];
    logic [2:0] ind_src;
    logic [2:0] pin_q, pin_d;

    assign func_sel[0] = ctl1_q[PFS_A_FUNC_LSB +: 3];
    assign func_sel[1] = ctl1_q[PFS_B_FUNC_LSB +: 3];
    assign func_sel[2] = ctl2_q[PFS_C_FUNC_LSB +: 3];
    assign clk_sel[0]  = {1'b0, ctl1_q[PFS_A_CLK_LSB +: 3]};
    assign clk_sel[1]  = {1'b0, ctl1_q[PFS_B_CLK_LSB +: 3]};
    assign clk_sel[2]  = ctl2_q[PFS_C_CLK_LSB +: PFS_C_CLK_W];
    assign ind_src     = {indicator_c_src, indicator_b_src, indicator_a_src};

    for (genvar g = 0; g < 3; g++) begin : g_pin
        logic sel_clk;
        logic pin_nx;

        // Undefined clock source codes give a steady low rather than a
        // guessed clock.
        always_comb begin
            if (clk_sel[g] == PFS_CS_CRYSTAL) begin
                sel_clk = crystal_input_clock;
            end else if (clk_sel[g] == PFS_CS_TRANSMIT) begin
                sel_clk = transmit_line_clock;
            end else begin
                sel_clk = 1'b0;
            end
        end

        always_comb begin
            unique case (pfs_func_t'(func_sel[g]))
                PFS_FN_INDICATOR: pin_nx = ind_src[g];
                PFS_FN_CLOCK:     pin_nx = sel_clk;
                PFS_FN_WAKE:      pin_nx = wake_on_lan_indication;
                PFS_FN_UNDERVOLT: pin_nx = undervoltage_indication;
                PFS_FN_TS_TX:     pin_nx = ts_transmit_event;
                PFS_FN_TS_RX:     pin_nx = ts_receive_event;
                PFS_FN_LOW:       pin_nx = 1'b0;
                PFS_FN_HIGH:      pin_nx = 1'b1;
            endcase
        end

        // Each lane drives only its own bit, by a continuous assignment,
        // so no variable is written from more than one process.
        assign pin_d[g] = pin_nx;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_q <= 3'h0;
        end else begin
            pin_q <= pin_d;
        end
    end

    assign indicator_pin_a  = pin_q[0];
    assign indicator_pin_b  = pin_q[1];
    assign clock_output_pin = pin_q[2];

endmodule : pfs_top

/* File: hw/pfs_pkg.sv */
package pfs_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [11:0] PFS_IDX_TERM = 12'h461;
    localparam logic [11:0] PFS_IDX_CTL1 = 12'h462;
    localparam logic [11:0] PFS_IDX_CTL2 = 12'h463;
    localparam int          PFS_ADDR_W   = 14;
    localparam logic [13:0] PFS_ADDR_TERM = {PFS_IDX_TERM, 2'b00};
    localparam logic [13:0] PFS_ADDR_CTL1 = {PFS_IDX_CTL1, 2'b00};
    localparam logic [13:0] PFS_ADDR_CTL2 = {PFS_IDX_CTL2, 2'b00};

    // ----------------------------------------------------------------
    // Reset values and writable masks
    // ----------------------------------------------------------------
    localparam logic [15:0] PFS_TERM_RST  = 16'h0410;
    localparam logic [15:0] PFS_CTL1_RST  = 16'h0000;
    localparam logic [15:0] PFS_CTL2_RST  = 16'h0001;
    localparam logic [15:0] PFS_TERM_MASK = 16'hffff;
    localparam logic [15:0] PFS_CTL1_MASK = 16'h7777;
    localparam logic [15:0] PFS_CTL2_MASK = 16'h00f7;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int PFS_TERM_LSB  = 1;
    localparam int PFS_TERM_W    = 4;
    localparam int PFS_A_FUNC_LSB = 0;
    localparam int PFS_A_CLK_LSB  = 4;
    localparam int PFS_B_FUNC_LSB = 8;
    localparam int PFS_B_CLK_LSB  = 12;
    localparam int PFS_C_FUNC_LSB = 0;
    localparam int PFS_C_CLK_LSB  = 4;
    localparam int PFS_C_CLK_W    = 4;

    // ----------------------------------------------------------------
    // Pin function and clock source codes
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        PFS_FN_INDICATOR = 3'b000,
        PFS_FN_CLOCK     = 3'b001,
        PFS_FN_WAKE      = 3'b010,
        PFS_FN_UNDERVOLT = 3'b011,
        PFS_FN_TS_TX     = 3'b100,
        PFS_FN_TS_RX     = 3'b101,
        PFS_FN_LOW       = 3'b110,
        PFS_FN_HIGH      = 3'b111
    } pfs_func_t;

    localparam logic [3:0] PFS_CS_CRYSTAL  = 4'h0;
    localparam logic [3:0] PFS_CS_TRANSMIT = 4'h1;

endpackage : pfs_pkg

/* File: verif/pfs_board.sv */
`timescale 1ns/1ps
module pfs_board (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [2:0] pins,
    output logic      [2:0] lamp_q
);
    // Lamps latch the pins once per cycle, so a one-cycle glitch still shows.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lamp_q <= 3'h0;
        end else begin
            lamp_q <= pins;
        end
    end
endmodule : pfs_board

/* File: verif/pfs_chk.sv */
`timescale 1ns/1ps
module pfs_chk (
    input wire logic pclk, presetn, psel, penable, pwrite, pready, pslverr,
    input wire logic [pfs_pkg::PFS_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata, prdata,
    input wire logic undervoltage_indication, ts_transmit_event,
    input wire logic indicator_pin_a, indicator_pin_b, clock_output_pin,
    input wire logic [pfs_pkg::PFS_TERM_W-1:0] rx_term_code
);
    import pfs_pkg::*;
    logic [3:0] wr_code;
    assign wr_code = pwdata[4:1];
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_wr(a);
        psel && penable && pready && pwrite && paddr == a;
    endsequence
    a_ready_one_late: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    a_err_unmapped: assert property (pready && paddr != PFS_ADDR_TERM && paddr != PFS_ADDR_CTL1
        && paddr != PFS_ADDR_CTL2 |-> pslverr) else $error("unmapped access not refused");
    a_term_follows: assert property (s_wr(PFS_ADDR_TERM) |=> ##1 rx_term_code == $past(wr_code, 2))
        else $error("termination code not applied");
    a_rsvd_read_zero: assert property (pready && !pwrite && paddr == PFS_ADDR_CTL1 |->
        (prdata[15:0] & ~PFS_CTL1_MASK) == 16'h0) else $error("reserved bits not zero");
    a_pin_a_low: assert property (s_wr(PFS_ADDR_CTL1) ##0 pwdata[2:0] == 3'b110
        |=> ##1 !indicator_pin_a) else $error("pin a not low");
    a_pin_b_high: assert property (s_wr(PFS_ADDR_CTL1) ##0 pwdata[10:8] == 3'b111
        |=> ##1 indicator_pin_b) else $error("pin b not high");
    a_uv_route: assert property (s_wr(PFS_ADDR_CTL1) ##0 pwdata[2:0] == 3'b011
        |=> ##1 indicator_pin_a == $past(undervoltage_indication)) else $error("uv not routed");
    a_ts_tx_route: assert property (s_wr(PFS_ADDR_CTL2) ##0 pwdata[2:0] == 3'b100
        |=> ##1 clock_output_pin == $past(ts_transmit_event)) else $error("ts not routed");
endmodule : pfs_chk
bind pfs_top pfs_chk u_chk (.*);

/* File: verif/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    import pfs_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [PFS_ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd, wd, exp;
    logic pready, pslverr, indicator_pin_a, indicator_pin_b, clock_output_pin, err;
    logic crystal_input_clock, transmit_line_clock, indicator_a_src, indicator_b_src;
    logic indicator_c_src, wake_on_lan_indication, undervoltage_indication;
    logic ts_transmit_event, ts_receive_event;
    logic [PFS_TERM_W-1:0] rx_term_code;
    logic [8:0] src = 9'h0;
    logic [2:0] lamp_q, fn;
    logic [3:0] ca, cb, cc;
    int error_cnt = 0, checked = 0, seed = 32'h62778205;
    assign {ts_receive_event, ts_transmit_event, undervoltage_indication, wake_on_lan_indication,
            indicator_c_src, indicator_b_src, indicator_a_src, transmit_line_clock,
            crystal_input_clock} = src;
    pfs_top u_dut (.*);
    pfs_board u_board (.pclk(pclk), .presetn(presetn), .lamp_q(lamp_q),
        .pins({clock_output_pin, indicator_pin_b, indicator_pin_a}));
    always #12.5 pclk = ~pclk;
    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        checked++;
        if (seen !== want) begin
            error_cnt++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, want);
        end
    endtask : chk
    task automatic results();
        $display("checked=%0d errors=%0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : results
    // Outputs are registered, so values read just after an edge are pre-edge.
    task automatic apb(input logic wr, input logic [PFS_ADDR_W-1:0] a, input logic [31:0] d);
        int n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20) begin
            n++;
            @(posedge pclk);
        end
        if (n == 20) error_cnt++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    function automatic logic pexp(input logic [2:0] f, input logic [3:0] cs, input logic ind);
        logic [7:0] v;
        v = {2'b10, src[8:5], (cs == 4'h0) ? src[0] : (cs == 4'h1) ? src[1] : 1'b0, ind};
        return v[f];
    endfunction : pexp
    initial begin
        #(25 * 4000);
        error_cnt++;
        results();
    end
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk(32'(rx_term_code), 32'h8);
        apb(1'b0, PFS_ADDR_TERM, 32'h0);
        chk(rd, 32'h410);
        apb(1'b0, PFS_ADDR_CTL1, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, PFS_ADDR_CTL2, 32'h0);
        chk(rd, 32'h1);
        apb(1'b0, 14'h0400, 32'h0);
        chk({rd[30:0], err}, 32'h1);
        $display("test reset_values done");
        for (int i = 0; i < 36; i++) begin
            wd = $random(seed);
            apb(1'b1, PFS_ADDR_TERM + 14'(4 * (i % 3)), wd);
            apb(1'b0, PFS_ADDR_TERM + 14'(4 * (i % 3)), 32'h0);
            exp = wd & 32'(i % 3 == 0 ? PFS_TERM_MASK : i % 3 == 1 ? PFS_CTL1_MASK : PFS_CTL2_MASK);
            chk(rd, exp);
            if (i % 3 == 0) chk(32'(rx_term_code), 32'(wd[4:1]));
        end
        $display("test register_access done");
        for (int k = 0; k < 32; k++) begin
            fn = 3'(k % 8);
            ca = 4'($random(seed)) & 4'h3;
            cb = 4'($random(seed)) & 4'h3;
            cc = 4'($random(seed)) & 4'h3;
            apb(1'b1, PFS_ADDR_CTL1, {16'h0, 1'b0, cb[2:0], 1'b0, fn, 1'b0, ca[2:0], 1'b0, fn});
            apb(1'b1, PFS_ADDR_CTL2, {24'h0, cc, 1'b0, fn});
            src <= 9'($random(seed));
            repeat (4) @(posedge pclk);
            exp = 32'({pexp(fn, cc, src[4]), pexp(fn, cb, src[3]), pexp(fn, ca, src[2])});
            chk(32'(lamp_q), exp);
        end
        $display("test pin_functions done");
        results();
    end
endmodule : tb_top
